// File: inc/fbcd_pkg.sv
/*
  Shared constants and types for the flash bus host controller.
  Assumes a 20 MHz clock and a byte-wide flash part with 19 address lines.
*/
package fbcd_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int STEP_W = 3;
  localparam int CNT_W = 4;
  localparam int WIN_W = 11;

  // Unlock and command addresses; upper bits are driven as zero.
  localparam logic [18:0] UNLOCK_ADDR_A = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR_B = 19'h02AAA;

  // Command data bytes.
  localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_IDENTITY = 8'h90;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;

  // Sequence lengths in bus write cycles.
  localparam logic [2:0] LEN_SINGLE = 3'h1;
  localparam logic [2:0] LEN_SHORT = 3'h3;
  localparam logic [2:0] LEN_PROGRAM = 3'h4;
  localparam logic [2:0] LEN_ERASE = 3'h6;

  // Bus cycle phase lengths in clock cycles.
  localparam logic [3:0] CYC_SETUP = 4'h1;
  localparam logic [3:0] CYC_WRITE = 4'h3;
  localparam logic [3:0] CYC_READ = 4'h6;
  localparam logic [3:0] CYC_HOLD = 4'h1;

  // Sector erase queue window, longest time rounded down to cycles.
  localparam int CLK_PERIOD_NS = 50;
  localparam int ERASE_WINDOW_NS = 80000;
  localparam logic [10:0] WINDOW_CYC = 11'(ERASE_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [10:0] WINDOW_GUARD = 11'h004;

  typedef enum logic [3:0] {
    CMD_READ, CMD_WRITE_RAW, CMD_RESET_SHORT, CMD_RESET_LONG, CMD_IDENTITY,
    CMD_PROGRAM, CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD,
    CMD_SUSPEND, CMD_RESUME, CMD_HV_ID_READ
  } fbcd_cmd_e;

  typedef struct packed {
    fbcd_cmd_e cmd;
    logic [18:0] addr;
    logic [7:0] data;
  } fbcd_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } fbcd_pins_s;
endpackage

// File: design/fbcd_cycle.sv
/*
  One asynchronous flash bus cycle, read or write, driven from registers.
  Assumes dq_in is already synchronised to clk by the caller.
*/
module fbcd_cycle (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic write,
  input wire logic [18:0] addr,
  input wire logic [7:0] data,
  input wire logic [7:0] dq_sync,
  output fbcd_pkg::fbcd_pins_s pins,
  output logic done,
  output logic [7:0] rd_data
);
  typedef enum {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fbcd_cyc_e;
  fbcd_cyc_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic wr, next_wr;
  logic next_done;
  logic [7:0] next_rd_data;
  fbcd_pkg::fbcd_pins_s next_pins;

  // Phase sequencing; pins follow the next phase so they come from flops.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_done = 1'b0;
    next_rd_data = rd_data;
    next_pins = pins;
    unique case (state)
      C_IDLE: if (start) begin
        next_state = C_SETUP;
        next_cnt = fbcd_pkg::CYC_SETUP;
        next_wr = write;
        next_pins.addr = addr;
        next_pins.dq_out = data;
      end
      C_SETUP: if (cnt == 4'h1) begin
        next_state = C_STROBE;
        next_cnt = wr ? fbcd_pkg::CYC_WRITE : fbcd_pkg::CYC_READ;
      end else begin
        next_cnt = cnt - 4'h1;
      end
      C_STROBE: if (cnt == 4'h1) begin
        next_state = C_HOLD;
        next_cnt = fbcd_pkg::CYC_HOLD;
        if (!wr) begin
          next_rd_data = dq_sync;
        end
      end else begin
        next_cnt = cnt - 4'h1;
      end
      C_HOLD: if (cnt == 4'h1) begin
        next_state = C_IDLE;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - 4'h1;
      end
    endcase
    // Chip select wraps the strobe; data is driven only while oe_n is high.
    next_pins.ce_n = (next_state == C_IDLE);
    next_pins.we_n = !(next_state == C_STROBE && next_wr);
    next_pins.oe_n = !(next_state == C_STROBE && !next_wr);
    next_pins.dq_oe = next_wr && next_state != C_IDLE;
  end

  // Registers of the cycle engine.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= C_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000,
                dq_out: 8'h00, dq_oe: 1'b0};
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      done <= next_done;
      rd_data <= next_rd_data;
      pins <= next_pins;
    end
  end

  a_no_dq_clash: assert property (@(posedge clk) disable iff (reset)
    pins.dq_oe |-> pins.oe_n) else $error("data driven while oe_n low");
  a_strobe_in_ce: assert property (@(posedge clk) disable iff (reset)
    (!pins.we_n || !pins.oe_n) |-> !pins.ce_n) else $error("strobe without ce");
  a_we_width: assert property (@(posedge clk) disable iff (reset || !clk_en)
    $fell(pins.we_n) |-> !pins.we_n[*3] ##1 pins.we_n) else $error("bad we width");
  a_data_hold: assert property (@(posedge clk) disable iff (reset || !clk_en)
    $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out)) else $error("data lost");
  c_write_cycle: cover property (@(posedge clk) disable iff (reset) $rose(pins.we_n));
  c_read_cycle: cover property (@(posedge clk) disable iff (reset) $rose(pins.oe_n));
endmodule // fbcd_cycle

// File: design/fbcd_host.sv
/*
  Host controller that drives a byte-wide sector-erase flash through its pins.
  Assumes a 20 MHz clock, an external switch that puts the identity voltage
  on address line nine when hv_id_enable is high, and a board that resolves
  the data bus from dq_oe.
*/
module fbcd_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire fbcd_pkg::fbcd_req_s req,
  output logic req_ready,
  output logic req_refused,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic erase_active,
  input wire logic [7:0] dq_in,
  output fbcd_pkg::fbcd_pins_s pins,
  output logic hv_id_enable
);
  typedef enum {T_IDLE, T_ISSUE, T_WAIT} fbcd_top_e;
  fbcd_top_e state, next_state;
  fbcd_pkg::fbcd_req_s cur, next_cur;
  logic [2:0] step, next_step;
  logic [10:0] window, next_window;
  logic next_erase_active, next_hv, next_ready, next_refused, next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic [7:0] dq_meta, dq_sync;
  logic cyc_done;
  logic [7:0] cyc_rd;
  logic cyc_write;
  logic [18:0] cyc_addr;
  logic [7:0] cyc_data;

  // Number of bus cycles for each command.
  function automatic logic [2:0] seq_len(fbcd_pkg::fbcd_cmd_e c);
    unique case (c)
      fbcd_pkg::CMD_RESET_LONG, fbcd_pkg::CMD_IDENTITY: return fbcd_pkg::LEN_SHORT;
      fbcd_pkg::CMD_PROGRAM: return fbcd_pkg::LEN_PROGRAM;
      fbcd_pkg::CMD_CHIP_ERASE, fbcd_pkg::CMD_SECTOR_ERASE: return fbcd_pkg::LEN_ERASE;
      default: return fbcd_pkg::LEN_SINGLE;
    endcase
  endfunction

  // Commands that put a read cycle on the bus.
  function automatic logic is_read(fbcd_pkg::fbcd_cmd_e c);
    return c == fbcd_pkg::CMD_READ || c == fbcd_pkg::CMD_HV_ID_READ;
  endfunction

  // Cycle address: unlock pattern, user address only where the device uses it.
  function automatic logic [18:0] seq_addr(fbcd_pkg::fbcd_req_s r, logic [2:0] s);
    logic last;
    last = (s == seq_len(r.cmd) - 3'h1);
    if (seq_len(r.cmd) == fbcd_pkg::LEN_SINGLE) begin
      return r.addr;
    end else if (s == 3'h1 || s == 3'h4) begin
      return fbcd_pkg::UNLOCK_ADDR_B;
    end else if (last && (r.cmd == fbcd_pkg::CMD_PROGRAM ||
                          r.cmd == fbcd_pkg::CMD_SECTOR_ERASE)) begin
      return r.addr;
    end
    return fbcd_pkg::UNLOCK_ADDR_A;
  endfunction

  // Cycle data byte for each step of each command.
  function automatic logic [7:0] seq_data(fbcd_pkg::fbcd_req_s r, logic [2:0] s);
    unique case (r.cmd)
      fbcd_pkg::CMD_RESET_SHORT: return fbcd_pkg::CODE_RESET;
      fbcd_pkg::CMD_SECTOR_ADD: return fbcd_pkg::CODE_SECTOR_ERASE;
      fbcd_pkg::CMD_SUSPEND: return fbcd_pkg::CODE_SUSPEND;
      fbcd_pkg::CMD_RESUME: return fbcd_pkg::CODE_RESUME;
      fbcd_pkg::CMD_READ, fbcd_pkg::CMD_WRITE_RAW, fbcd_pkg::CMD_HV_ID_READ: return r.data;
      default: begin
        if (s == 3'h0 || s == 3'h3) begin
          return (r.cmd == fbcd_pkg::CMD_PROGRAM && s == 3'h3) ? r.data
                                                               : fbcd_pkg::UNLOCK_DATA_A;
        end else if (s == 3'h1 || s == 3'h4) begin
          return fbcd_pkg::UNLOCK_DATA_B;
        end else if (s == 3'h5) begin
          return (r.cmd == fbcd_pkg::CMD_CHIP_ERASE) ? fbcd_pkg::CODE_CHIP_ERASE
                                                     : fbcd_pkg::CODE_SECTOR_ERASE;
        end
        unique case (r.cmd)
          fbcd_pkg::CMD_RESET_LONG: return fbcd_pkg::CODE_RESET;
          fbcd_pkg::CMD_IDENTITY: return fbcd_pkg::CODE_IDENTITY;
          fbcd_pkg::CMD_PROGRAM: return fbcd_pkg::CODE_PROGRAM;
          default: return fbcd_pkg::CODE_ERASE_SETUP;
        endcase
      end
    endcase
  endfunction

  // Two-flop synchroniser for the data pins.
  always_ff @(posedge clk) begin
    if (reset) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end else if (clk_en) begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  // Values handed to the cycle engine for the current step.
  assign cyc_write = !is_read(cur.cmd);
  assign cyc_addr = seq_addr(cur, step);
  assign cyc_data = seq_data(cur, step);

  // Command sequencer: acceptance, stepping and erase window tracking.
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_window = (window != 11'h000) ? window - 11'h001 : window;
    next_erase_active = erase_active;
    next_hv = hv_id_enable;
    next_refused = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    unique case (state)
      T_IDLE: if (req_valid && req_ready) begin
        if ((req.cmd == fbcd_pkg::CMD_SECTOR_ADD && window <= fbcd_pkg::WINDOW_GUARD) ||
            ((req.cmd == fbcd_pkg::CMD_SUSPEND || req.cmd == fbcd_pkg::CMD_RESUME) &&
             !erase_active)) begin
          next_refused = 1'b1;
        end else begin
          next_cur = req;
          next_step = 3'h0;
          next_hv = (req.cmd == fbcd_pkg::CMD_HV_ID_READ);
          next_state = T_ISSUE;
        end
      end
      T_ISSUE: next_state = T_WAIT;
      T_WAIT: if (cyc_done) begin
        if (step != seq_len(cur.cmd) - 3'h1) begin
          next_step = step + 3'h1;
          next_state = T_ISSUE;
        end else begin
          next_state = T_IDLE;
          next_hv = 1'b0;
          next_rsp_valid = is_read(cur.cmd);
          next_rsp_data = cyc_rd;
          unique case (cur.cmd)
            fbcd_pkg::CMD_SECTOR_ERASE, fbcd_pkg::CMD_SECTOR_ADD: begin
              next_window = fbcd_pkg::WINDOW_CYC;
              next_erase_active = 1'b1;
            end
            fbcd_pkg::CMD_SUSPEND: next_window = 11'h000;
            fbcd_pkg::CMD_READ, fbcd_pkg::CMD_HV_ID_READ, fbcd_pkg::CMD_RESUME: begin
            end
            default: begin
              next_window = 11'h000;
              next_erase_active = 1'b0;
            end
          endcase
        end
      end
    endcase
    next_ready = (next_state == T_IDLE);
  end

  // Registers of the sequencer; after reset the device is taken as in read mode.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= T_IDLE;
      cur <= '{cmd: fbcd_pkg::CMD_READ, addr: 19'h00000, data: 8'h00};
      step <= 3'h0;
      window <= 11'h000;
      erase_active <= 1'b0;
      hv_id_enable <= 1'b0;
      req_ready <= 1'b0;
      req_refused <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      window <= next_window;
      erase_active <= next_erase_active;
      hv_id_enable <= next_hv;
      req_ready <= next_ready;
      req_refused <= next_refused;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  fbcd_cycle u_cycle (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(state == T_ISSUE),
    .write(cyc_write),
    .addr(cyc_addr),
    .data(cyc_data),
    .dq_sync(dq_sync),
    .pins(pins),
    .done(cyc_done),
    .rd_data(cyc_rd)
  );

  a_unlock_first: assert property (@(posedge clk) disable iff (reset)
    (state == T_ISSUE && step == 3'h0 && seq_len(cur.cmd) != fbcd_pkg::LEN_SINGLE) |->
    cyc_addr == fbcd_pkg::UNLOCK_ADDR_A && cyc_data == fbcd_pkg::UNLOCK_DATA_A)
    else $error("sequence without unlock");
  a_cmd_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (state == T_ISSUE && cur.cmd == fbcd_pkg::CMD_CHIP_ERASE) |-> cyc_addr[18:15] == 4'h0)
    else $error("upper address bits on command");
  a_suspend_refused: assert property (@(posedge clk) disable iff (reset || !clk_en)
    (req_valid && req_ready && req.cmd == fbcd_pkg::CMD_SUSPEND && !erase_active) |=>
    req_refused && state == T_IDLE) else $error("suspend taken outside erase");
  a_short_reset: assert property (@(posedge clk) disable iff (reset)
    (state == T_ISSUE && cur.cmd == fbcd_pkg::CMD_RESET_SHORT) |->
    cyc_data == fbcd_pkg::CODE_RESET && cyc_write) else $error("bad reset byte");
  a_window_load: assert property (@(posedge clk) disable iff (reset || !clk_en)
    (state == T_WAIT && cyc_done && cur.cmd == fbcd_pkg::CMD_SECTOR_ERASE &&
     step == 3'h5) |=> window == fbcd_pkg::WINDOW_CYC) else $error("window not opened");
  a_hv_read_only: assert property (@(posedge clk) disable iff (reset)
    hv_id_enable |-> pins.we_n) else $error("write under identity voltage");
  c_sector_erase: cover property (@(posedge clk) disable iff (reset)
    state == T_WAIT && cyc_done && cur.cmd == fbcd_pkg::CMD_SECTOR_ERASE && step == 3'h5);
  c_hv_read: cover property (@(posedge clk) disable iff (reset) hv_id_enable && rsp_valid);
endmodule // fbcd_host

// File: bench/fbcd_flash_model.sv
/*
  Behavioural model of the byte-wide sector-erase flash on the far side of the host.
  Assumes the bench resolves the data bus and feeds it back as bus.
*/
module fbcd_flash_model #(
  parameter logic [7:0] PROTECT = 8'h00,
  parameter logic [7:0] MAKER_ID = 8'h07, // Arbitrary identity value, odd parity.
  parameter logic [7:0] DEVICE_ID = 8'h8C // Arbitrary identity value, odd parity.
) (
  input wire fbcd_pkg::fbcd_pins_s pins,
  input wire logic hv_id,
  input wire logic [7:0] bus,
  output logic [7:0] dev_dq,
  output logic dev_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:524287];
  logic [18:0] lat_a;
  logic [2:0] step;
  logic id_mode, prog, erasing, susp, armed, wr;

  // Erases one sector unless it is protected.
  task automatic erase_sector(input logic [2:0] s);
    if (!PROTECT[s]) begin
      for (int i = 0; i < 65536; i++) mem[{s, 16'(i)}] = 8'hFF;
    end
  endtask

  // Reads give array data, or identity bytes in identity mode.
  function automatic logic [7:0] rd_byte(input logic [18:0] a, input logic idm);
    if (!idm) return mem[a];
    if (a[1]) return {7'h00, PROTECT[a[18:16]]};
    return a[0] ? DEVICE_ID : MAKER_ID;
  endfunction

  // Decodes one completed write cycle.
  task automatic command(input logic [18:0] a, input logic [7:0] d);
    logic [14:0] c;
    logic [2:0] nx;
    c = a[14:0];
    nx = 3'h0;
    if (prog) begin
      if (!PROTECT[a[18:16]]) mem[a] = mem[a] & d;
      prog = 1'b0;
    end else if (erasing && d == 8'hB0) begin
      susp = 1'b1;
    end else if (erasing && d == 8'h30) begin
      if (susp) susp = 1'b0;
      else erase_sector(a[18:16]);
    end else if (d == 8'hF0) begin
      id_mode = 1'b0;
      erasing = 1'b0;
      susp = 1'b0;
    end else begin
      id_mode = 1'b0;
      erasing = 1'b0;
      case (step)
        3'h0, 3'h3: if (c == 15'h5555 && d == 8'hAA) nx = step + 3'h1;
        3'h1, 3'h4: if (c == 15'h2AAA && d == 8'h55) nx = step + 3'h1;
        3'h2: if (c == 15'h5555) begin
          if (d == 8'h90) id_mode = 1'b1;
          if (d == 8'hA0) prog = 1'b1;
          if (d == 8'h80) nx = 3'h3;
        end
        default: begin
          if (c == 15'h5555 && d == 8'h10) begin
            for (int s = 0; s < 8; s++) erase_sector(3'(s));
          end
          if (d == 8'h30) begin
            erase_sector(a[18:16]);
            erasing = 1'b1;
          end
        end
      endcase
    end
    step = nx;
  endtask

  // Power-up state: read mode with an erased array.
  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    step = 3'h0;
    id_mode = 1'b0;
    prog = 1'b0;
    erasing = 1'b0;
    susp = 1'b0;
    armed = 1'b0;
  end

  // Data pins are driven only when selected with outputs enabled.
  assign dev_en = !pins.ce_n && !pins.oe_n;
  assign dev_dq = rd_byte(pins.addr, hv_id | id_mode);
  assign wr = !pins.ce_n && !pins.we_n && pins.oe_n;

  // Address at the later falling strobe, data at the earlier rising one.
  always @(posedge wr) begin
    lat_a = pins.addr;
    armed = 1'b1;
  end
  always @(negedge wr) begin
    if (armed) command(lat_a, bus);
    armed = 1'b0;
  end
endmodule // fbcd_flash_model

// File: bench/fbcd_host_test.sv
/*
  Self-checking bench for the flash host controller with a flash model.
  Assumes the package and the design files are compiled first.
*/
module fbcd_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAKER = 8'h07; // Arbitrary identity value.
  localparam logic [7:0] DEVICE = 8'h8C; // Arbitrary identity value.
  typedef struct {
    fbcd_pkg::fbcd_cmd_e cmd;
    logic [18:0] a;
    logic [7:0] d;
    logic [7:0] exp;
    logic [2:0] f; // Bit 0 check read, bit 1 refused, bit 2 erase active.
  } fbcd_row_s;
  logic clk, reset, req_valid, req_ready, req_refused, rsp_valid, erase_active;
  logic hv_id_enable, dev_en, clk_en;
  logic [7:0] rsp_data, dev_dq, float_pat, bus;
  fbcd_pkg::fbcd_req_s req;
  fbcd_pkg::fbcd_pins_s pins;
  int bad_count, n_tests;
  fbcd_row_s rows [31] = '{
    '{fbcd_pkg::CMD_READ, 19'h00100, 8'h00, 8'hFF, 3'h1},
    '{fbcd_pkg::CMD_PROGRAM, 19'h12345, 8'h3C, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h12345, 8'h00, 8'h3C, 3'h1},
    '{fbcd_pkg::CMD_PROGRAM, 19'h32000, 8'h5A, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_PROGRAM, 19'h20010, 8'h00, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h20010, 8'h00, 8'hFF, 3'h1},
    '{fbcd_pkg::CMD_SUSPEND, 19'h00000, 8'hB0, 8'h00, 3'h2},
    '{fbcd_pkg::CMD_IDENTITY, 19'h00000, 8'h90, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h00000, 8'h00, MAKER, 3'h1},
    '{fbcd_pkg::CMD_READ, 19'h12345, 8'h00, DEVICE, 3'h1},
    '{fbcd_pkg::CMD_READ, 19'h20002, 8'h00, 8'h01, 3'h1},
    '{fbcd_pkg::CMD_READ, 19'h10002, 8'h00, 8'h00, 3'h1},
    '{fbcd_pkg::CMD_RESET_LONG, 19'h00000, 8'hF0, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h12345, 8'h00, 8'h3C, 3'h1},
    '{fbcd_pkg::CMD_WRITE_RAW, 19'h05555, 8'hAA, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_WRITE_RAW, 19'h05555, 8'h90, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h00000, 8'h00, 8'hFF, 3'h1},
    '{fbcd_pkg::CMD_IDENTITY, 19'h00000, 8'h90, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_RESET_SHORT, 19'h4ABCD, 8'hF0, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h00001, 8'h00, 8'hFF, 3'h1},
    '{fbcd_pkg::CMD_SECTOR_ERASE, 19'h30000, 8'h30, 8'h00, 3'h4},
    '{fbcd_pkg::CMD_SECTOR_ADD, 19'h20000, 8'h30, 8'h00, 3'h4},
    '{fbcd_pkg::CMD_SUSPEND, 19'h00000, 8'hB0, 8'h00, 3'h4},
    '{fbcd_pkg::CMD_READ, 19'h12345, 8'h00, 8'h3C, 3'h5},
    '{fbcd_pkg::CMD_RESUME, 19'h00000, 8'h30, 8'h00, 3'h4},
    '{fbcd_pkg::CMD_READ, 19'h32000, 8'h00, 8'hFF, 3'h5},
    '{fbcd_pkg::CMD_RESET_SHORT, 19'h00000, 8'hF0, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_CHIP_ERASE, 19'h00000, 8'h10, 8'h00, 3'h0},
    '{fbcd_pkg::CMD_READ, 19'h12345, 8'h00, 8'hFF, 3'h1},
    '{fbcd_pkg::CMD_HV_ID_READ, 19'h7FF81, 8'h00, DEVICE, 3'h1},
    '{fbcd_pkg::CMD_HV_ID_READ, 19'h00000, 8'h00, MAKER, 3'h1}
  };

  fbcd_host i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .req_refused(req_refused), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .erase_active(erase_active), .dq_in(bus), .pins(pins),
    .hv_id_enable(hv_id_enable));
  fbcd_flash_model #(.PROTECT(8'h04), .MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) i_flash (
    .pins(pins), .hv_id(hv_id_enable), .bus(bus), .dev_dq(dev_dq), .dev_en(dev_en));

  // The released bus shows a changing pattern rather than its last value.
  assign bus = dev_en ? dev_dq : (pins.dq_oe ? pins.dq_out : float_pat);
  always @(posedge clk) float_pat <= reset ? 8'h5A : ~float_pat;

  // Compares one value and reports a mismatch.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Issues one request and collects read data and refusal.
  task automatic do_req(input fbcd_pkg::fbcd_cmd_e c, input logic [18:0] a,
      input logic [7:0] d, output logic [7:0] got, output logic rf);
    int k;
    got = 8'h00;
    rf = 1'b0;
    k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k == 400) check({7'h00, req_ready}, 8'h01);
    req = '{cmd: c, addr: a, data: d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; k < 400; k++) begin
      if (rsp_valid === 1'b1) got = rsp_data;
      if (req_refused === 1'b1) rf = 1'b1;
      if (k > 0 && req_ready === 1'b1) break;
      @(negedge clk);
    end
    if (k == 400) check({7'h00, req_ready}, 8'h01);
  endtask

  // Watches the strobes for illegal writes and bus fights.
  always @(negedge clk) begin
    if (!reset && !pins.we_n) check({7'h00, pins.oe_n & !pins.ce_n}, 8'h01);
    if (!reset && pins.dq_oe) check({7'h00, dev_en}, 8'h00);
  end

  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // Table walk, then window expiry and a mid-run reset.
  initial begin
    logic [7:0] got;
    logic rf;
    fbcd_pkg::fbcd_pins_s held;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    clk_en = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      do_req(rows[i].cmd, rows[i].a, rows[i].d, got, rf);
      if (rows[i].f[0]) check(got, rows[i].exp);
      check({7'h00, rf}, {7'h00, rows[i].f[1]});
      check({7'h00, erase_active}, {7'h00, rows[i].f[2]});
    end
    // A low clock enable freezes a read in mid-strobe; it then completes.
    do_req(fbcd_pkg::CMD_PROGRAM, 19'h12345, 8'hC3, got, rf);
    req = '{cmd: fbcd_pkg::CMD_READ, addr: 19'h12345, data: 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (4) @(negedge clk);
    held = pins;
    clk_en = 1'b0;
    repeat (6) @(negedge clk);
    check({7'h00, pins == held}, 8'h01);
    check({7'h00, pins.oe_n}, 8'h00);
    clk_en = 1'b1;
    repeat (20) @(negedge clk);
    check(rsp_data, 8'hC3);
    check({7'h00, req_ready}, 8'h01);
    do_req(fbcd_pkg::CMD_SECTOR_ERASE, 19'h50000, 8'h30, got, rf);
    repeat (1700) @(negedge clk);
    do_req(fbcd_pkg::CMD_SECTOR_ADD, 19'h60000, 8'h30, got, rf);
    check({7'h00, rf}, 8'h01);
    req = '{cmd: fbcd_pkg::CMD_READ, addr: 19'h00100, data: 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (3) @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    check({4'h0, pins.ce_n, pins.dq_oe, req_ready, hv_id_enable}, 8'h08);
    reset = 1'b0;
    do_req(fbcd_pkg::CMD_READ, 19'h00100, 8'h00, got, rf);
    check(got, 8'hFF);
    end_sim();
  end
endmodule // fbcd_host_test
